// ===== rtl/gpc_pkg.sv
// Contract
// - Direction 1 makes pin input, high impedance; 0 drives latch bit.
// - First port is eight bidirectional pins with data, latch, direction bits.
// - Reading latch register returns stored latch, not pin level.
// - Peripherals may override pin direction to output or to input.
// - Override never enters direction register; reads return software value.
// - Second port is eight pins, each independently input or output.
// - Mode bit 4 of shared register selects slave port; clear returns GPIO.
// - Third port is three bidirectional pins, each input or output.
// - In slave mode third port bits 0,1,2 are read, write, chip select.
// - Third port pin selected analog reads zero in data register.
// - Input buffer full flag bit 7 set while received word unread.
// - Overflow bit 5 set on write before prior word read; software clears.
// - Bit 6 is read-only output buffer full flag.
// - Bit 3 reads zero; shared register resets to 0000 0111.
// - Both 8-bit direction registers reset to all ones.
// - Data register reads pins, writes latch; third port keeps low 3 bits.
package gpc_pkg;

   // ----------------------------------------
   // Register map (word index on the plain port)
   // ----------------------------------------
   localparam logic [3:0] ADDR_C_PINS  = 4'h0;
   localparam logic [3:0] ADDR_C_LATCH = 4'h1;
   localparam logic [3:0] ADDR_C_DIR   = 4'h2;
   localparam logic [3:0] ADDR_D_PINS  = 4'h3;
   localparam logic [3:0] ADDR_D_LATCH = 4'h4;
   localparam logic [3:0] ADDR_D_DIR   = 4'h5;
   localparam logic [3:0] ADDR_E_PINS  = 4'h6;
   localparam logic [3:0] ADDR_E_LATCH = 4'h7;
   localparam logic [3:0] ADDR_E_DIR   = 4'h8;

   // ----------------------------------------
   // Shared direction/status register fields
   // ----------------------------------------
   localparam int BIT_IBF     = 7;
   localparam int BIT_OBF     = 6;
   localparam int BIT_INPUT_OVERFLOW_FLAG    = 5;
   localparam int BIT_SLAVE_PORT_MODE_SELECT = 4;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_DIR8  = 8'hFF;
   localparam logic [2:0] RST_DIR3  = 3'h7;
   localparam logic [7:0] RST_LATCH = 8'h00;

   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } gpc_bus_t;

   // Peripheral override for one 8-bit port
   typedef struct packed {
      logic [7:0] claim;
      logic [7:0] oe;
      logic [7:0] val;
   } gpc_ovr_t;

endpackage

// ===== rtl/gpc_ports.sv
`timescale 1ns/10ps
`default_nettype none
module gpc_ports (
   // Clock and reset
   input  wire logic              mclk_in,
   input  wire logic              srst_in,
   // Register port
   input  wire gpc_pkg::gpc_bus_t bus_in,
   output logic [7:0]             rdata_out,
   // Peripheral overrides
   input  wire gpc_pkg::gpc_ovr_t ovr_c_in,
   input  wire gpc_pkg::gpc_ovr_t ovr_d_in,
   input  wire logic [2:0]        ovr_e_claim_in,
   input  wire logic [2:0]        ovr_e_oe_in,
   input  wire logic [2:0]        ovr_e_val_in,
   input  wire logic [2:0]        e_analog_in,
   // Pins
   input  wire logic [7:0]        c_pin_in,
   output logic [7:0]             c_pin_out,
   output logic [7:0]             c_pin_oe_out,
   input  wire logic [7:0]        d_pin_in,
   output logic [7:0]             d_pin_out,
   output logic [7:0]             d_pin_oe_out,
   input  wire logic [2:0]        e_pin_in,
   output logic [2:0]             e_pin_out,
   output logic [2:0]             e_pin_oe_out,
   // Slave port status
   output logic                   slave_mode_out,
   output logic                   slave_ibf_out
);
   import gpc_pkg::*;

   typedef struct packed {
      logic [7:0] c_lat, c_dir, c_s1, c_s2;
      logic [7:0] d_lat, d_dir, d_s1, d_s2;
      logic [2:0] e_lat, e_dir, e_s1, e_s2;
      logic       mode, input_buffer_full_flag, output_buffer_full_flag, input_overflow_flag;
      logic       wr_act, rd_act;
      logic [7:0] rdata;
   } gpc_state_t;

   gpc_state_t st_ff;
   gpc_state_t nxt_st;
   logic       ps_wr;
   logic       ps_rd;
   logic       ps_wr_edge;
   logic       ps_rd_edge;
   logic [7:0] d_oe_gpio;

   // ----------------------------------------
   // External slave strobes (active low, synchronised)
   // ----------------------------------------
   assign ps_rd      = st_ff.mode && !st_ff.e_s2[0] && !st_ff.e_s2[2];
   assign ps_wr      = st_ff.mode && !st_ff.e_s2[1] && !st_ff.e_s2[2];
   assign ps_wr_edge = ps_wr && !st_ff.wr_act;
   assign ps_rd_edge = ps_rd && !st_ff.rd_act;

   always_comb begin
      nxt_st        = st_ff;
      // Second stage only reads the first
      nxt_st.c_s1   = c_pin_in;
      nxt_st.c_s2   = st_ff.c_s1;
      nxt_st.d_s1   = d_pin_in;
      nxt_st.d_s2   = st_ff.d_s1;
      nxt_st.e_s1   = e_pin_in;
      nxt_st.e_s2   = st_ff.e_s1;
      nxt_st.wr_act = ps_wr;
      nxt_st.rd_act = ps_rd;
      nxt_st.rdata  = 8'h00;

      // External master read empties the output buffer
      if (ps_rd_edge) begin
         nxt_st.output_buffer_full_flag = 1'b0;
      end

      if (bus_in.wr) begin
         unique case (bus_in.addr)
            ADDR_C_PINS, ADDR_C_LATCH: nxt_st.c_lat = bus_in.wdata;
            ADDR_C_DIR:                nxt_st.c_dir = bus_in.wdata;
            ADDR_D_PINS, ADDR_D_LATCH: begin
               nxt_st.d_lat = bus_in.wdata;
               // Loading the latch in slave mode presents a word to the master
               if (st_ff.mode) begin
                  nxt_st.output_buffer_full_flag = 1'b1;
               end
            end
            ADDR_D_DIR:                nxt_st.d_dir = bus_in.wdata;
            ADDR_E_PINS, ADDR_E_LATCH: nxt_st.e_lat = bus_in.wdata[2:0];
            ADDR_E_DIR: begin
               nxt_st.e_dir = bus_in.wdata[2:0];
               nxt_st.mode  = bus_in.wdata[BIT_SLAVE_PORT_MODE_SELECT];
               if (!bus_in.wdata[BIT_INPUT_OVERFLOW_FLAG]) begin
                  nxt_st.input_overflow_flag = 1'b0;
               end
            end
            default: ;
         endcase
      end

      if (bus_in.rd) begin
         unique case (bus_in.addr)
            ADDR_C_PINS:  nxt_st.rdata = st_ff.c_s2;
            ADDR_C_LATCH: nxt_st.rdata = st_ff.c_lat;
            ADDR_C_DIR:   nxt_st.rdata = st_ff.c_dir;
            ADDR_D_PINS: begin
               // In slave mode the port reads the captured input word
               nxt_st.rdata = st_ff.mode ? st_ff.d_lat : st_ff.d_s2;
               if (st_ff.mode) begin
                  nxt_st.input_buffer_full_flag = 1'b0;
               end
            end
            ADDR_D_LATCH: nxt_st.rdata = st_ff.d_lat;
            ADDR_D_DIR:   nxt_st.rdata = st_ff.d_dir;
            ADDR_E_PINS:  nxt_st.rdata = {5'h00, st_ff.e_s2 & ~e_analog_in};
            ADDR_E_LATCH: nxt_st.rdata = {5'h00, st_ff.e_lat};
            ADDR_E_DIR:   nxt_st.rdata = {st_ff.input_buffer_full_flag, st_ff.output_buffer_full_flag, st_ff.input_overflow_flag, st_ff.mode,
                                          1'b0, st_ff.e_dir};
            default:      nxt_st.rdata = 8'h00;
         endcase
      end

      // External write: capture word; set beats any clear in the same cycle
      if (ps_wr_edge) begin
         nxt_st.d_lat = st_ff.d_s2;
         nxt_st.input_buffer_full_flag   = 1'b1;
         if (st_ff.input_buffer_full_flag) begin
            nxt_st.input_overflow_flag = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         st_ff       <= '0;
         st_ff.c_lat <= RST_LATCH;
         st_ff.d_lat <= RST_LATCH;
         st_ff.e_lat <= RST_LATCH[2:0];
         st_ff.c_dir <= RST_DIR8;
         st_ff.d_dir <= RST_DIR8;
         st_ff.e_dir <= RST_DIR3;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   // Slave mode drives the port only during an external read
   assign d_oe_gpio = st_ff.mode ? {8{ps_rd}} : ~st_ff.d_dir;

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         c_pin_oe_out[i] = ovr_c_in.claim[i] ? ovr_c_in.oe[i] : ~st_ff.c_dir[i];
         c_pin_out[i]    = ovr_c_in.claim[i] ? ovr_c_in.val[i] : st_ff.c_lat[i];
         d_pin_oe_out[i] = ovr_d_in.claim[i] ? ovr_d_in.oe[i] : d_oe_gpio[i];
         d_pin_out[i]    = ovr_d_in.claim[i] ? ovr_d_in.val[i] : st_ff.d_lat[i];
      end
      for (int j = 0; j < 3; j++) begin
         // Direction bits still steer drivers when pins are analog
         e_pin_oe_out[j] = ovr_e_claim_in[j] ? ovr_e_oe_in[j] : ~st_ff.e_dir[j];
         e_pin_out[j]    = ovr_e_claim_in[j] ? ovr_e_val_in[j] : st_ff.e_lat[j];
      end
   end

   assign rdata_out      = st_ff.rdata;
   assign slave_mode_out = st_ff.mode;
   assign slave_ibf_out  = st_ff.input_buffer_full_flag;

endmodule // gpc_ports
`default_nettype wire

// ===== verification/gpc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module gpc_checker
   import gpc_pkg::*;
(
   // Clock and reset
   input wire logic       mclk_in,
   input wire logic       srst_in,
   // Observed ports
   input wire gpc_bus_t   bus_in,
   input wire logic [7:0] rdata_out,
   input wire gpc_ovr_t   ovr_c_in,
   input wire logic [7:0] c_pin_oe_out,
   input wire logic [2:0] ovr_e_claim_in,
   input wire logic [2:0] ovr_e_oe_in,
   input wire logic [2:0] e_pin_oe_out,
   input wire logic [2:0] e_analog_in,
   input wire logic       slave_mode_out,
   input wire logic       slave_ibf_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   sequence rd_at(logic [3:0] a); bus_in.rd && bus_in.addr == a; endsequence
   idle_rd_zero_a: assert property (!bus_in.rd |=> rdata_out == 8'h00) else $error("idle read data");
   c_claim_oe_a: assert property (
      (c_pin_oe_out & ovr_c_in.claim) == (ovr_c_in.oe & ovr_c_in.claim)) else $error("c claim");
   e_claim_oe_a: assert property (
      (e_pin_oe_out & ovr_e_claim_in) == (ovr_e_oe_in & ovr_e_claim_in)) else $error("e claim");
   mode_wr_a: assert property (
      bus_in.wr && bus_in.addr == ADDR_E_DIR |=> slave_mode_out == $past(bus_in.wdata[4])) else $error("mode write");
   gap_zero_a: assert property (rd_at(ADDR_E_DIR) |=> !rdata_out[3]) else $error("bit 3");
   ibf_rd_a: assert property (rd_at(ADDR_E_DIR) |=> rdata_out[7] == $past(slave_ibf_out)) else $error("ibf read");
   ibf_clr_a: assert property (rd_at(ADDR_D_PINS) ##0 slave_mode_out |=> !slave_ibf_out) else $error("ibf clear");
   analog_a: assert property (
      rd_at(ADDR_E_PINS) |=> (rdata_out[2:0] & $past(e_analog_in)) == 3'h0 && rdata_out[7:3] == 5'h00)
      else $error("analog read");
endmodule // gpc_checker
bind gpc_ports gpc_checker u_checker (.mclk_in, .srst_in, .bus_in, .rdata_out, .ovr_c_in, .c_pin_oe_out,
   .ovr_e_claim_in, .ovr_e_oe_in, .e_pin_oe_out, .e_analog_in, .slave_mode_out, .slave_ibf_out);
`default_nettype wire

// ===== verification/gpc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// Outside circuitry on one port: weak drivers, so the block's driver always wins
module gpc_pin_model #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] drv_in,
   input  wire logic [W-1:0] oe_in,
   input  wire logic [W-1:0] ext_in,
   output logic [W-1:0]      level_out
);
   assign level_out = (drv_in & oe_in) | (ext_in & ~oe_in);
endmodule // gpc_pin_model
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import gpc_pkg::*;
   logic       mclk_in = 1'b0;
   logic       srst_in = 1'b1;
   gpc_bus_t   bus_in = '0;
   gpc_ovr_t   ovr_c_in = '0, ovr_d_in = '0;
   logic [2:0] ovr_e_claim_in = 3'h0, ovr_e_oe_in = 3'h0, ovr_e_val_in = 3'h0, e_analog_in = 3'h0, ex = 3'h7;
   logic [7:0] cx = 8'h00, dx = 8'h00, c_pin_in, c_pin_out, c_pin_oe_out, d_pin_in, d_pin_out, d_pin_oe_out;
   logic [7:0] rdata_out;
   logic [2:0] e_pin_in, e_pin_out, e_pin_oe_out;
   logic       slave_mode_out, slave_ibf_out;
   int         fails = 0, total_checks = 0;
   initial forever #5 mclk_in = ~mclk_in;
   gpc_ports dut (.*);
   gpc_pin_model #(.W(8)) m_c (.drv_in(c_pin_out), .oe_in(c_pin_oe_out), .ext_in(cx), .level_out(c_pin_in));
   gpc_pin_model #(.W(8)) m_d (.drv_in(d_pin_out), .oe_in(d_pin_oe_out), .ext_in(dx), .level_out(d_pin_in));
   gpc_pin_model #(.W(3)) m_e (.drv_in(e_pin_out), .oe_in(e_pin_oe_out), .ext_in(ex), .level_out(e_pin_in));
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_in);
      bus_in.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_in);
      bus_in.rd <= 1'b0;
      #1 chk("rdata", rdata_out, e);
   endtask
   // External write cycle: chip select and write strobe low, then released
   task automatic ext_wr(input logic [7:0] d);
      @(posedge mclk_in);
      dx <= d;
      ex <= 3'h1;
      repeat (4) @(posedge mclk_in);
      ex <= 3'h7;
      repeat (4) @(posedge mclk_in);
   endtask
   // External read cycle: chip select and read strobe low, port must drive the latch
   task automatic ext_rd(input logic [7:0] e);
      @(posedge mclk_in);
      ex <= 3'h2;
      repeat (4) @(posedge mclk_in);
      #1 chk("d_oe", d_pin_oe_out, 8'hFF);
      chk("d_out", d_pin_out, e);
      chk("d_lvl", d_pin_in, e);
      @(posedge mclk_in);
      ex <= 3'h7;
      repeat (4) @(posedge mclk_in);
   endtask
   task automatic t_reset;
      rd(ADDR_C_DIR, 8'hFF);
      rd(ADDR_D_DIR, 8'hFF);
      rd(ADDR_E_DIR, 8'h07);
      rd(4'hC, 8'h00);
   endtask
   task automatic t_port_c;
      wr(ADDR_C_PINS, 8'h3C);
      rd(ADDR_C_LATCH, 8'h3C);
      wr(ADDR_C_LATCH, 8'hA5);
      wr(ADDR_C_DIR, 8'h0F);
      @(posedge mclk_in);
      cx <= 8'h96;
      ovr_c_in <= '{claim: 8'h81, oe: 8'h01, val: 8'h01};
      repeat (3) @(posedge mclk_in);
      chk("c_oe", c_pin_oe_out, 8'h71);
      chk("c_out", c_pin_out & 8'h71, 8'h21);
      rd(ADDR_C_DIR, 8'h0F);
      rd(ADDR_C_LATCH, 8'hA5);
      rd(ADDR_C_PINS, 8'hA7);
   endtask
   task automatic t_port_d_e;
      wr(ADDR_D_DIR, 8'h55);
      wr(ADDR_E_LATCH, 8'hFF);
      wr(ADDR_E_DIR, 8'h02);
      @(posedge mclk_in);
      ovr_e_claim_in <= 3'h4;
      e_analog_in <= 3'h2;
      repeat (3) @(posedge mclk_in);
      chk("d_oe", d_pin_oe_out, 8'hAA);
      chk("e_oe", {5'h00, e_pin_oe_out}, 8'h01);
      chk("e_out", {5'h00, e_pin_out & 3'h1}, 8'h01);
      rd(ADDR_E_LATCH, 8'h07);
      rd(ADDR_E_PINS, 8'h05);
   endtask
   task automatic t_slave;
      wr(ADDR_D_DIR, 8'hFF);
      wr(ADDR_E_DIR, 8'h17);
      #1 chk("mode", {7'h00, slave_mode_out}, 8'h01);
      ext_wr(8'h5A);
      rd(ADDR_E_DIR, 8'h97);
      ext_wr(8'hC3);
      rd(ADDR_E_DIR, 8'hB7);
      rd(ADDR_D_PINS, 8'hC3);
      wr(ADDR_E_DIR, 8'h37);
      rd(ADDR_E_DIR, 8'h37);
      wr(ADDR_E_DIR, 8'h17);
      wr(ADDR_D_LATCH, 8'h11);
      rd(ADDR_E_DIR, 8'h57);
      ext_rd(8'h11);
      rd(ADDR_E_DIR, 8'h17);
      wr(ADDR_E_DIR, 8'h07);
      #1 chk("mode", {7'h00, slave_mode_out}, 8'h00);
   endtask
   task automatic wrap_up;
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge mclk_in);
      srst_in <= 1'b0;
      t_reset;
      t_port_c;
      t_port_d_e;
      t_slave;
      wrap_up;
   end
   // Whole run needs about a hundred cycles
   initial begin
      repeat (2000) @(posedge mclk_in);
      fails++;
      wrap_up;
   end
endmodule // testbench
`default_nettype wire
